// file: shared/nv_host_pkg.sv
// Constants and carrier types for the nonvolatile memory host controller
package nv_host_pkg;
    // ==========================================================
    // Widths
    localparam int ADDR_W = 17; // Full memory address width
    localparam int CMD_ADDR_W = 16; // Only these bits steer command decoding
    localparam int DATA_W = 8;
    localparam int SEQ_LEN = 6; // Reads per software command
    localparam logic [2:0] SEQ_LAST = 3'h5; // Index of the sixth read

    // ==========================================================
    // Command sequence addresses
    localparam logic [15:0] SEQ_A0 = 16'h4E38;
    localparam logic [15:0] SEQ_A1 = 16'hB1C7;
    localparam logic [15:0] SEQ_A2 = 16'h83E0;
    localparam logic [15:0] SEQ_A3 = 16'h7C1F;
    localparam logic [15:0] SEQ_A4 = 16'h703F;
    localparam logic [15:0] CMD_SAVE_OFF = 16'h8B45; // Power-loss save disable
    localparam logic [15:0] CMD_SAVE_ON = 16'h4B46; // Power-loss save enable
    localparam logic [15:0] CMD_STORE = 16'h8FC0;
    localparam logic [15:0] CMD_RECALL = 16'h4C63;

    // ==========================================================
    // Operation and software command codes
    localparam logic [2:0] OP_READ = 3'h1;
    localparam logic [2:0] OP_WRITE = 3'h2;
    localparam logic [2:0] OP_SWCMD = 3'h3;
    localparam logic [2:0] OP_HWSTORE = 3'h4;
    localparam logic [1:0] SW_STORE = 2'h0;
    localparam logic [1:0] SW_RECALL = 2'h1;
    localparam logic [1:0] SW_SAVE_OFF = 2'h2;
    localparam logic [1:0] SW_SAVE_ON = 2'h3;

    // ==========================================================
    // Register map and fields
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_WDATA = 8'h08;
    localparam logic [7:0] REG_RDATA = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_SW_LSB = 4;
    localparam int ST_BUSY = 0;
    localparam int ST_DONE = 1;
    localparam int ST_REFUSED = 2;
    localparam int ST_LINE = 3;

    // ==========================================================
    // Timing
    localparam int CLK_NS = 50;
    localparam int STROBE_NS = 45; // Read cycle / strobe width, least
    localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam int HW_PULSE_NS = 15; // Hardware store pulse, least
    localparam int HW_PULSE_CYC = (HW_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int SOFT_SEQ_US = 70; // Soft sequence processing, waited in full
    localparam int SOFT_SEQ_CYC = (SOFT_SEQ_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int HW_DELAY_US = 70; // Time before the device pulls the line low
    localparam int HW_DELAY_CYC = (HW_DELAY_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int TIMER_W = 12;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic ceN;
        logic weN;
        logic oeN;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dqOut;
        logic dqOe;
    } memPins_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic write;
        logic [DATA_W-1:0] data;
    } accessReq_t;
endpackage : nv_host_pkg

// file: design/nv_access_unit.sv
// One chip-select controlled memory access on the asynchronous pins
`timescale 1ns/1ps
module nv_access_unit (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic start,
    input wire nv_host_pkg::accessReq_t req,
    input wire logic [nv_host_pkg::DATA_W-1:0] dqIn,
    output nv_host_pkg::memPins_t pins,
    output logic done,
    output logic [nv_host_pkg::DATA_W-1:0] rdata
);
    import nv_host_pkg::*;

    // ==========================================================
    // State
    typedef enum logic [3:0] {
        AC_IDLE = 4'b0001,
        AC_SETUP = 4'b0010,
        AC_STROBE = 4'b0100,
        AC_RECOVER = 4'b1000
    } acState_t;

    acState_t stateReg, stateNext; // Access phase
    memPins_t pinsReg, pinsNext; // Registered pin image
    logic [TIMER_W-1:0] cntReg, cntNext; // Strobe length
    logic doneReg, doneNext; // Completion pulse
    logic [DATA_W-1:0] rdataReg, rdataNext; // Captured read byte

    // Pins released: every strobe high, bus not driven
    function automatic memPins_t idlePins(input memPins_t p);
        memPins_t r;
        r = p;
        r.ceN = 1'b1;
        r.weN = 1'b1;
        r.oeN = 1'b1;
        r.dqOe = 1'b0;
        return r;
    endfunction : idlePins

    // ==========================================================
    // Next state
    always_comb begin
        stateNext = stateReg;
        pinsNext = pinsReg;
        cntNext = cntReg;
        doneNext = 1'b0;
        rdataNext = rdataReg;
        unique case (stateReg)
            AC_IDLE: begin
                // Address settles while chip select is still high
                if (start) begin
                    pinsNext = idlePins(pinsReg);
                    pinsNext.addr = req.addr;
                    pinsNext.dqOut = req.data;
                    stateNext = AC_SETUP;
                end
            end
            AC_SETUP: begin
                // Reads keep the write strobe high; output drive low
                pinsNext.ceN = 1'b0;
                pinsNext.weN = ~req.write;
                pinsNext.oeN = req.write;
                pinsNext.dqOe = req.write;
                cntNext = TIMER_W'(STROBE_CYC - 1);
                stateNext = AC_STROBE;
            end
            AC_STROBE: begin
                if (cntReg == '0) begin
                    // Sample before releasing; rising edge ends the cycle
                    if (!req.write) begin
                        rdataNext = dqIn;
                    end
                    pinsNext = idlePins(pinsReg);
                    doneNext = 1'b1;
                    stateNext = AC_RECOVER;
                end else begin
                    cntNext = cntReg - TIMER_W'(1);
                end
            end
            AC_RECOVER: begin
                // One idle cycle gives each access its own falling edge
                stateNext = AC_IDLE;
            end
        endcase
    end

    // Registers only
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            stateReg <= AC_IDLE;
            pinsReg <= memPins_t'({3'b111, {(ADDR_W + DATA_W + 1){1'b0}}});
            cntReg <= '0;
            doneReg <= 1'b0;
            rdataReg <= '0;
        end else begin
            stateReg <= stateNext;
            pinsReg <= pinsNext;
            cntReg <= cntNext;
            doneReg <= doneNext;
            rdataReg <= rdataNext;
        end
    end

    assign pins = pinsReg;
    assign done = doneReg;
    assign rdata = rdataReg;

    // ==========================================================
    // Checks
    sequence s_select;
        $fell(pinsReg.ceN);
    endsequence

    property p_strobe_one;
        @(posedge core_clk) disable iff (sys_rst) s_select |=> pinsReg.ceN && doneReg;
    endproperty
    a_strobe_one: assert property (p_strobe_one) else $error("strobe not one cycle"); // [R14]

    property p_no_both_strobes;
        @(posedge core_clk) disable iff (sys_rst) !(!pinsReg.weN && !pinsReg.oeN);
    endproperty
    a_no_both_strobes: assert property (p_no_both_strobes) else $error("write and output drive low"); // [R15]
endmodule : nv_access_unit

// file: design/nv_host_ctrl.sv
// Host controller driving a nonvolatile static memory, commanded over APB
//
// Behaviour
// [R1] Commands are six reads, fixed five-address prefix
// [R2] Sixth read 0x8B45 disables power-loss save
// [R3] Sixth read 0x4B46 enables power-loss save
// [R4] Sixth read 0x8FC0 starts store, bus floats
// [R5] Sixth read 0x4C63 starts recall, bus floats
// [R6] Host issues six addresses consecutively, in order
// [R7] Write strobe stays high through all six
// [R8] Only low sixteen address bits are compared
// [R9] Data driven only while output drive low
// [R10] Save setting persists only after a store
// [R11] Fresh device defaults to save enabled
// [R12] Low supply blocks stores and writes
// [R13] Write held low at power-up is suppressed
// [R14] Read: select, output drive low, lines high
// [R15] Write: select and write strobe low
// [R16] No other access may interrupt a sequence
// [R17] Auto and hardware store need prior write
// [R18] Mismatched read resets tracker, prefix restarts it
// [R19] Disabled save blocks only the automatic store
//
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module nv_host_ctrl (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output nv_host_pkg::memPins_t memPins,
    input wire logic [nv_host_pkg::DATA_W-1:0] dqIn,
    input wire logic storeBusyIn,
    output logic storeBusyOut,
    output logic storeBusyOe
);
    import nv_host_pkg::*;

    // ==========================================================
    // State
    typedef enum logic [5:0] {
        M_IDLE = 6'b000001,
        M_WAIT_LINE = 6'b000010,
        M_ACCESS = 6'b000100,
        M_SETTLE = 6'b001000,
        M_HW_PULSE = 6'b010000,
        M_HW_WAIT = 6'b100000
    } mainState_t;

    mainState_t stateReg, stateNext; // Operation sequencer
    logic [2:0] opReg, opNext; // Current operation
    logic [1:0] swReg, swNext; // Selected software command
    logic [2:0] stepReg, stepNext; // Position in a command sequence
    logic [TIMER_W-1:0] timerReg, timerNext; // Shared wait counter
    logic [ADDR_W-1:0] addr_reg, addrNext; // Array address
    logic [DATA_W-1:0] wdata_reg, wdataNext; // Byte to write
    logic [DATA_W-1:0] rdataReg, rdataNext; // Last byte read
    logic doneReg, doneNext; // Sticky completion
    logic refusedReg, refusedNext; // Sticky refused command
    logic lineOeReg, lineOeNext; // Store request pulls the line

    logic apbWrite; // Access phase of an APB write
    logic startAcc; // Launch one pin access
    logic accDone; // Pin access finished
    logic [DATA_W-1:0] accData; // Byte returned by the access
    accessReq_t accReq; // Access presented to the pin unit

    // Address of a given read within a software command
    function automatic logic [15:0] seqAddr(input logic [2:0] step, input logic [1:0] sw);
        logic [15:0] a;
        a = SEQ_A0;
        unique case (step)
            3'h0: a = SEQ_A0;
            3'h1: a = SEQ_A1;
            3'h2: a = SEQ_A2;
            3'h3: a = SEQ_A3;
            3'h4: a = SEQ_A4;
            default: begin
                unique case (sw)
                    SW_STORE: a = CMD_STORE; // [R4] [R10]
                    SW_RECALL: a = CMD_RECALL; // [R5]
                    SW_SAVE_OFF: a = CMD_SAVE_OFF; // [R2]
                    SW_SAVE_ON: a = CMD_SAVE_ON; // [R3]
                endcase
            end
        endcase
        return a;
    endfunction : seqAddr

    // ==========================================================
    // Pin access unit
    always_comb begin
        // Sequence reads: top address bit held low, never a write
        if (opReg == OP_SWCMD) begin
            accReq.addr = {1'b0, seqAddr(stepReg, swReg)}; // [R1] [R8]
            accReq.write = 1'b0; // [R7]
        end else begin
            accReq.addr = addr_reg;
            accReq.write = (opReg == OP_WRITE); // [R15]
        end
        accReq.data = wdata_reg;
    end

    nv_access_unit nv_access_unit_i (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .start(startAcc),
        .req(accReq),
        .dqIn(dqIn),
        .pins(memPins),
        .done(accDone),
        .rdata(accData)
    );

    // ==========================================================
    // Sequencer and registers, next values
    assign apbWrite = psel && penable && pwrite;

    always_comb begin
        stateNext = stateReg;
        opNext = opReg;
        swNext = swReg;
        stepNext = stepReg;
        timerNext = timerReg;
        addrNext = addr_reg;
        wdataNext = wdata_reg;
        rdataNext = rdataReg;
        doneNext = doneReg;
        refusedNext = refusedReg;
        startAcc = 1'b0;
        // Software clears sticky bits by writing ones
        if (apbWrite && paddr == REG_STATUS) begin
            if (pwdata[ST_DONE]) begin
                doneNext = 1'b0;
            end
            if (pwdata[ST_REFUSED]) begin
                refusedNext = 1'b0;
            end
        end
        // Operands only change while idle, so a sequence stays intact
        if (apbWrite && stateReg == M_IDLE) begin
            if (paddr == REG_ADDR) begin
                addrNext = pwdata[ADDR_W-1:0];
            end
            if (paddr == REG_WDATA) begin
                wdataNext = pwdata[DATA_W-1:0];
            end
        end
        unique case (stateReg)
            M_IDLE: begin
                if (apbWrite && paddr == REG_CMD) begin
                    opNext = pwdata[CMD_OP_LSB +: 3];
                    swNext = pwdata[CMD_SW_LSB +: 2];
                    stepNext = '0;
                    unique case (pwdata[CMD_OP_LSB +: 3])
                        OP_READ, OP_WRITE, OP_SWCMD: stateNext = M_WAIT_LINE;
                        OP_HWSTORE: begin
                            timerNext = TIMER_W'(HW_PULSE_CYC - 1);
                            stateNext = M_HW_PULSE;
                        end
                        default: refusedNext = 1'b1; // Unknown operation
                    endcase
                end
            end
            M_WAIT_LINE: begin
                // Device accepts no access while it holds the line low
                if (storeBusyIn) begin
                    startAcc = 1'b1; // [R14]
                    stateNext = M_ACCESS;
                end
            end
            M_ACCESS: begin
                if (accDone) begin
                    if (opReg == OP_SWCMD && stepReg != SEQ_LAST) begin
                        // Next read follows with nothing in between
                        stepNext = stepReg + 3'h1; // [R6] [R16]
                        stateNext = M_WAIT_LINE;
                    end else if (opReg == OP_SWCMD) begin
                        timerNext = TIMER_W'(SOFT_SEQ_CYC - 1);
                        stateNext = M_SETTLE;
                    end else begin
                        if (opReg == OP_READ) begin
                            rdataNext = accData;
                        end
                        doneNext = 1'b1;
                        stateNext = M_IDLE;
                    end
                end
            end
            M_SETTLE: begin
                // Device needs this long to act on the sixth read
                if (timerReg == '0) begin
                    doneNext = 1'b1;
                    stateNext = M_IDLE;
                end else begin
                    timerNext = timerReg - TIMER_W'(1);
                end
            end
            M_HW_PULSE: begin
                if (timerReg == '0) begin
                    timerNext = TIMER_W'(HW_DELAY_CYC - 1);
                    stateNext = M_HW_WAIT;
                end else begin
                    timerNext = timerReg - TIMER_W'(1);
                end
            end
            M_HW_WAIT: begin
                // Give the device time to claim the line, then wait for release
                if (timerReg != '0) begin
                    timerNext = timerReg - TIMER_W'(1);
                end else if (storeBusyIn) begin
                    doneNext = 1'b1;
                    stateNext = M_IDLE;
                end
            end
        endcase
        // A command while busy is dropped; set wins over a clear
        if (apbWrite && paddr == REG_CMD && stateReg != M_IDLE) begin
            refusedNext = 1'b1; // [R16]
        end
        lineOeNext = (stateNext == M_HW_PULSE);
    end

    // Registers only
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            stateReg <= M_IDLE;
            opReg <= '0;
            swReg <= '0;
            stepReg <= '0;
            timerReg <= '0;
            addr_reg <= '0;
            wdata_reg <= '0;
            rdataReg <= '0;
            doneReg <= 1'b0;
            refusedReg <= 1'b0;
            lineOeReg <= 1'b0;
        end else begin
            stateReg <= stateNext;
            opReg <= opNext;
            swReg <= swNext;
            stepReg <= stepNext;
            timerReg <= timerNext;
            addr_reg <= addrNext;
            wdata_reg <= wdataNext;
            rdataReg <= rdataNext;
            doneReg <= doneNext;
            refusedReg <= refusedNext;
            lineOeReg <= lineOeNext;
        end
    end

    // Open-drain: only ever pulls low
    assign storeBusyOut = 1'b0;
    assign storeBusyOe = lineOeReg;

    // ==========================================================
    // APB read side; zero wait states
    assign pready = 1'b1;

    always_comb begin
        prdata = '0;
        pslverr = 1'b0;
        unique case (paddr)
            REG_CMD: prdata = {26'h0, swReg, 1'b0, opReg};
            REG_ADDR: prdata = {15'h0, addr_reg};
            REG_WDATA: prdata = {24'h0, wdata_reg};
            REG_RDATA: prdata = {24'h0, rdataReg};
            REG_STATUS: begin
                prdata[ST_BUSY] = (stateReg != M_IDLE);
                prdata[ST_DONE] = doneReg;
                prdata[ST_REFUSED] = refusedReg;
                prdata[ST_LINE] = storeBusyIn;
            end
            default: pslverr = psel && penable; // Unmapped offset
        endcase
    end

    // ==========================================================
    // Checks
    property p_seq_we_high;
        @(posedge core_clk) disable iff (sys_rst) (opReg == OP_SWCMD && stateReg == M_ACCESS) |-> memPins.weN;
    endproperty
    a_seq_we_high: assert property (p_seq_we_high) else $error("write strobe low in sequence"); // [R7]

    property p_seq_msb_low;
        @(posedge core_clk) disable iff (sys_rst) (opReg == OP_SWCMD && !memPins.ceN) |-> !memPins.addr[ADDR_W-1];
    endproperty
    a_seq_msb_low: assert property (p_seq_msb_low) else $error("top address bit set in sequence"); // [R8]

    property p_first_addr;
        @(posedge core_clk) disable iff (sys_rst)
            (opReg == OP_SWCMD && stepReg == 3'h0 && !memPins.ceN) |-> memPins.addr[15:0] == SEQ_A0;
    endproperty
    a_first_addr: assert property (p_first_addr) else $error("first sequence address wrong"); // [R1]

    property p_store_addr;
        @(posedge core_clk) disable iff (sys_rst)
            (opReg == OP_SWCMD && swReg == SW_STORE && stepReg == SEQ_LAST && !memPins.ceN)
            |-> memPins.addr[15:0] == CMD_STORE;
    endproperty
    a_store_addr: assert property (p_store_addr) else $error("store address wrong"); // [R4]

    property p_recall_addr;
        @(posedge core_clk) disable iff (sys_rst)
            (opReg == OP_SWCMD && swReg == SW_RECALL && stepReg == SEQ_LAST && !memPins.ceN)
            |-> memPins.addr[15:0] == CMD_RECALL;
    endproperty
    a_recall_addr: assert property (p_recall_addr) else $error("recall address wrong"); // [R5]

    property p_off_addr;
        @(posedge core_clk) disable iff (sys_rst)
            (opReg == OP_SWCMD && swReg == SW_SAVE_OFF && stepReg == SEQ_LAST && !memPins.ceN)
            |-> memPins.addr[15:0] == CMD_SAVE_OFF;
    endproperty
    a_off_addr: assert property (p_off_addr) else $error("save disable address wrong"); // [R2]

    property p_on_addr;
        @(posedge core_clk) disable iff (sys_rst)
            (opReg == OP_SWCMD && swReg == SW_SAVE_ON && stepReg == SEQ_LAST && !memPins.ceN)
            |-> memPins.addr[15:0] == CMD_SAVE_ON;
    endproperty
    a_on_addr: assert property (p_on_addr) else $error("save enable address wrong"); // [R3]

    property p_step_order;
        @(posedge core_clk) disable iff (sys_rst)
            stepReg != $past(stepReg) |-> stepReg == 3'h0 || stepReg == $past(stepReg) + 3'h1;
    endproperty
    a_step_order: assert property (p_step_order) else $error("sequence step out of order"); // [R6]

    property p_read_drive;
        @(posedge core_clk) disable iff (sys_rst) (!memPins.ceN && memPins.weN) |-> !memPins.oeN && !memPins.dqOe;
    endproperty
    a_read_drive: assert property (p_read_drive) else $error("read without output drive"); // [R9]
endmodule : nv_host_ctrl

// file: verification/nv_device_model.sv
// Behavioural model of the nonvolatile memory behind the pins
`timescale 1ns/1ps
module nv_device_model (
    input wire logic core_clk,
    input wire nv_host_pkg::memPins_t pins,
    input wire logic lineLow,
    output logic [7:0] dq,
    output logic devBusy
);
    import nv_host_pkg::*;
    // ==========================================================
    // State
    localparam int BUSY_CYC = 1500; // Store time, shortened; longer than the host's wait
    logic [7:0] mem [0:131071]; // Whole byte array
    logic [15:0] seq [0:4] = '{SEQ_A0, SEQ_A1, SEQ_A2, SEQ_A3, SEQ_A4};
    logic [2:0] step = 3'h0; // Reads matched so far
    logic saveOn = 1'b1; // Fresh part saves on power loss
    logic nvSave = 1'b1; // Committed copy of the setting
    logic written = 1'b0; // Write since last store or recall
    logic ceQ = 1'b1;
    logic [7:0] lastDq = 8'h00;
    logic [3:0] storeCnt = 4'h0;
    logic [3:0] recallCnt = 4'h0;
    int hold = 0;
    wire [15:0] a = pins.addr[15:0]; // Top address bit ignored
    wire hiZ = step == 3'h5 && (a == CMD_STORE || a == CMD_RECALL);
    wire rd = !pins.ceN && !pins.oeN && pins.weN && !hiZ && !devBusy;
    assign devBusy = hold != 0;
    // Released bus flips, so a stale value never reads as valid
    assign dq = pins.dqOe ? pins.dqOut : rd ? mem[pins.addr] : ~lastDq;
    // ==========================================================
    // Access decoding on each falling chip select
    always @(posedge core_clk) begin
        lastDq <= dq;
        ceQ <= pins.ceN;
        if (hold != 0) hold <= hold - 1;
        if (ceQ && !pins.ceN) begin
            if (!pins.weN) begin
                step <= 3'h0;
                mem[pins.addr] <= pins.dqOut;
                written <= 1'b1;
            end else if (step == 3'h5) begin
                step <= 3'h0;
                if (a == CMD_SAVE_OFF) saveOn <= 1'b0;
                if (a == CMD_SAVE_ON) saveOn <= 1'b1;
                if (a == CMD_STORE) begin
                    storeCnt <= storeCnt + 4'h1;
                    nvSave <= saveOn;
                    written <= 1'b0;
                end
                if (a == CMD_RECALL) begin
                    recallCnt <= recallCnt + 4'h1;
                    written <= 1'b0;
                end
            end else begin
                step <= (a == seq[step]) ? step + 3'h1 : {2'h0, a == SEQ_A0};
            end
        end else if (lineLow && !devBusy && written) begin
            hold <= BUSY_CYC;
            storeCnt <= storeCnt + 4'h1;
            nvSave <= saveOn;
            written <= 1'b0;
        end
    end
endmodule : nv_device_model

// file: verification/nv_host_ctrl_tb.sv
// Self-checking testbench of the nonvolatile host controller
`timescale 1ns/1ps
module nv_host_ctrl_tb;
    import nv_host_pkg::*;
    typedef struct packed { logic [16:0] a; logic [7:0] d; } row_t;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd, st;
    logic pready, pslverr, err, storeBusyOut, storeBusyOe, devBusy;
    logic [7:0] dqIn;
    memPins_t memPins;
    int fail_count = 0;
    int n_tests = 0;
    int cyc = 0;
    // Same low bits with and without the top bit, plus the last byte
    row_t rows [3] = '{'{17'h14E38, 8'h5A}, '{17'h04E38, 8'hA5}, '{17'h1FFFF, 8'h01}};
    logic [1:0] sw [4] = '{2'h2, 2'h0, 2'h3, 2'h1};
    logic [2:0] ex [4] = '{3'h0, 3'h2, 3'h6, 3'h7}; // Save on, one store, one recall
    wire storeBusyIn = !(storeBusyOe || devBusy); // Line has a pull-up
    always #25 core_clk = ~core_clk;
    nv_host_ctrl nv_host_ctrl_i (.core_clk(core_clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .memPins(memPins), .dqIn(dqIn), .storeBusyIn(storeBusyIn),
        .storeBusyOut(storeBusyOut), .storeBusyOe(storeBusyOe));
    nv_device_model nv_device_model_i (.core_clk(core_clk), .pins(memPins), .lineLow(storeBusyOe),
        .dq(dqIn), .devBusy(devBusy));
    // ==========================================================
    // Bus and check tasks
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task chk(input string n, input logic [31:0] e, input logic [31:0] s);
        n_tests++;
        if (s !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    // Poll until done, keep the status, then clear the sticky bits
    task waitDone;
        do apb(1'b0, REG_STATUS, 32'h0); while (rd[ST_DONE] !== 1'b1);
        st = rd;
        apb(1'b1, REG_STATUS, 32'h6);
    endtask : waitDone
    task access(input logic [2:0] op, input row_t r);
        apb(1'b1, REG_ADDR, {15'h0, r.a});
        apb(1'b1, REG_WDATA, {24'h0, r.d});
        apb(1'b1, REG_CMD, {29'h0, op});
        waitDone;
    endtask : access
    task tally_and_finish;
        $display("Checks %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : tally_and_finish
    // Hang guard, well above the roughly 9000 cycles needed
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 40000) begin
            fail_count++;
            tally_and_finish;
        end
    end
    // ==========================================================
    // Main sequence
    initial begin
        repeat (8) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        chk("idle pins", 5'h1C, {memPins.ceN, memPins.weN, memPins.oeN, memPins.dqOe, storeBusyOe});
        apb(1'b0, REG_STATUS, 32'h0);
        chk("reset status", 32'h8, rd);
        $display("Reset test done");
        foreach (rows[i]) begin
            access(OP_WRITE, rows[i]);
            access(OP_READ, '{rows[i].a, 8'h00});
            apb(1'b0, REG_RDATA, 32'h0);
            chk("read back", {24'h0, rows[i].d}, rd);
        end
        $display("Access rows done");
        foreach (sw[i]) begin
            apb(1'b1, REG_CMD, {26'h0, sw[i], 1'b0, OP_SWCMD});
            waitDone;
            chk("sw command", ex[i], {nv_device_model_i.saveOn, nv_device_model_i.storeCnt == 4'h1,
                nv_device_model_i.recallCnt == 4'h1});
        end
        chk("saved setting", 1'b0, nv_device_model_i.nvSave);
        apb(1'b0, REG_CMD, 32'h0);
        chk("cmd readback", 32'h13, rd);
        $display("Software commands done");
        apb(1'b1, REG_CMD, {29'h0, OP_HWSTORE});
        waitDone;
        chk("idle store", 4'h1, nv_device_model_i.storeCnt);
        access(OP_WRITE, rows[2]);
        apb(1'b1, REG_CMD, {29'h0, OP_HWSTORE});
        apb(1'b1, REG_CMD, {29'h0, OP_READ});
        waitDone;
        chk("busy refusal", 1'b1, st[ST_REFUSED]);
        chk("hw store", 4'h2, nv_device_model_i.storeCnt);
        $display("Hardware store done");
        apb(1'b1, REG_CMD, 32'h7);
        apb(1'b0, REG_STATUS, 32'h0);
        chk("bad op", 1'b1, rd[ST_REFUSED]);
        apb(1'b0, 8'h14, 32'h0);
        chk("unmapped err", 1'b1, err);
        chk("unmapped data", 32'h0, rd);
        $display("Refusal test done");
        tally_and_finish;
    end
endmodule : nv_host_ctrl_tb
